// [rtl/ats_cfg.svh]
// register indices, field positions, reset values and encodings of the timer block
`ifndef ATS_CFG_SVH
`define ATS_CFG_SVH

// register indices; the wishbone byte address is four times the index
`define ATS_IDX_FLAGS 8'h37
`define ATS_IDX_GTC 8'h43
`define ATS_IDX_MASK 8'h70
`define ATS_IDX_CTLA 8'hb0
`define ATS_IDX_CTLB 8'hb1
`define ATS_IDX_CNT 8'hb2
`define ATS_IDX_CMPA 8'hb3
`define ATS_IDX_CMPB 8'hb4
`define ATS_IDX_ASYNC_STATUS 8'hb6

// field positions
`define ATS_BIT_TSM 7
`define ATS_BIT_EXT 6
`define ATS_BIT_ASYNC 5
`define ATS_BIT_PSR 1

// buffered register slots, equal to their busy bit positions
`define ATS_BUF_CNT 4
`define ATS_BUF_CMPA 3
`define ATS_BUF_CMPB 2
`define ATS_BUF_CTLA 1
`define ATS_BUF_CTLB 0

// writable bits of the control and compare registers
`define ATS_WMASK_CTLA 8'hf3
`define ATS_WMASK_CTLB 8'h0f
`define ATS_WMASK_CMP 8'hff

// reset values and counter limits
`define ATS_RST_BYTE 8'h00
`define ATS_RST_FLAGS 3'h0
`define ATS_CNT_MAX 8'hff
`define ATS_CNT_BOTTOM 8'h00

// compare output actions
`define ATS_COM_TOGGLE 2'h1
`define ATS_COM_CLEAR 2'h2
`define ATS_COM_SET 2'h3

// waveform modes
`define ATS_WGM_PC 2'h1
`define ATS_WGM_CTC 3'h2

// prescaler tap masks for clock selects 2..7
`define ATS_PS_DIV8 10'h007
`define ATS_PS_DIV32 10'h01f
`define ATS_PS_DIV64 10'h03f
`define ATS_PS_DIV128 10'h07f
`define ATS_PS_DIV256 10'h0ff
`define ATS_PS_DIV1024 10'h3ff

`endif

// [rtl/ats_pkg.sv]
// types shared by the timer block
package ats_pkg;
	typedef logic [7:0] ats_byte_t;
	typedef logic [2:0] ats_clksel_t;
	typedef enum logic {ATS_UP, ATS_DOWN} ats_dir_t;
endpackage

// [rtl/ats_pin_sync.sv]
// three-flop synchroniser for the oscillator pin with rising-edge pulse
`timescale 1ns/100ps
`default_nettype none
module ats_pin_sync (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronised reset, active low
	input wire logic clk_en, // freezes state while low
	input wire logic pin, // asynchronous pin level
	output logic rise // one-cycle pulse on a confirmed rising edge
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;

	// a level counts once the second and third stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
		end else if (clk_en) begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
		end
	end

	assign rise = clk_en & ~lvl_q & s2_q & s3_q;
endmodule
`default_nettype wire

// [rtl/ats_prescaler.sv]
// ten-bit prescaler with clock-select tap
`timescale 1ns/100ps
`default_nettype none
`include "ats_cfg.svh"
module ats_prescaler import ats_pkg::*; (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronised reset, active low
	input wire logic clk_en, // freezes state while low
	input wire logic src_tick, // timer source clock event
	input wire logic clr, // holds the prescaler in reset
	input wire ats_clksel_t sel, // clock select
	output logic tick // counter clock event
);
	logic [9:0] cnt_q;
	logic [9:0] tap;

	// divide by 2^n fires when the low bits are all ones
	assign tap = (sel == 3'h2) ? `ATS_PS_DIV8 :
		(sel == 3'h3) ? `ATS_PS_DIV32 :
		(sel == 3'h4) ? `ATS_PS_DIV64 :
		(sel == 3'h5) ? `ATS_PS_DIV128 :
		(sel == 3'h6) ? `ATS_PS_DIV256 : `ATS_PS_DIV1024;
	assign tick = clk_en & src_tick & ~clr & (sel != 3'h0)
		& ((sel == 3'h1) | ((cnt_q & tap) == tap));

	// count source events unless held in reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 10'h000;
		end else if (clk_en) begin
			if (clr) begin
				cnt_q <= 10'h000;
			end else if (src_tick) begin
				cnt_q <= cnt_q + 10'h001;
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/ats_timer.sv]
// 8-bit timer with asynchronous clocking, buffered registers, flags and wishbone slave
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ats_cfg.svh"
module ats_timer import ats_pkg::*; (
	input wire logic ref_clk, // 100 MHz clock
	input wire logic resetn, // asynchronous reset, active low
	input wire logic clk_en, // freezes all state except the reset synchroniser while low
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [9:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte enables
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	input wire logic timer_osc_input_pin, // asynchronous oscillator input
	input wire logic global_irq_enable, // cpu status word interrupt bit
	input wire logic [2:0] irq_vector_ack, // vector executed: cmp b, cmp a, ovf
	output logic [2:0] irq_request, // interrupt requests: cmp b, cmp a, ovf
	output logic wave_out_a, // waveform output a
	output logic wave_out_b, // waveform output b
	output logic osc_run, // crystal oscillator enable
	output logic ext_clk_buf_en, // external clock input buffer enable
	output logic prescaler_reset // prescaler reset state
);
	logic rst_s_q;
	logic rst_n;
	logic ack_q;
	logic [31:0] dat_q;
	logic [2:0] flags_q;
	logic [2:0] mask_q;
	logic tsm_q;
	logic psr_q;
	logic ext_q;
	logic async_q;
	logic [4:0] busy;
	ats_byte_t cnt_q;
	ats_byte_t cnt_tmp_q;
	ats_dir_t dir_q;
	logic block_q;
	logic [2:0] irq_q;
	logic wave_a_q;
	logic wave_b_q;
	logic osc_run_q;
	logic ext_buf_q;

	// reset release through two flops
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_s_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s_q <= 1'b1;
			rst_n <= rst_s_q;
		end
	end

	// bus decode
	wire req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire [7:0] idx = wb_adr_i[9:2];
	wire wr = req & wb_we_i & wb_sel_i[0];
	wire rd = req & ~wb_we_i;
	wire ats_byte_t wd = wb_dat_i[7:0];
	wire wr_flags = wr & (idx == `ATS_IDX_FLAGS);
	wire wr_gtc = wr & (idx == `ATS_IDX_GTC);
	wire wr_mask = wr & (idx == `ATS_IDX_MASK);
	wire wr_async_status = wr & (idx == `ATS_IDX_ASYNC_STATUS);
	wire wr_cnt = wr & (idx == `ATS_IDX_CNT);
	wire [3:0] wr_buf = {wr & (idx == `ATS_IDX_CMPA), wr & (idx == `ATS_IDX_CMPB),
		wr & (idx == `ATS_IDX_CTLA), wr & (idx == `ATS_IDX_CTLB)};
	// indexed by buffer slot: 0 control b, 1 control a, 2 compare b, 3 compare a
	wire ats_byte_t wmask [4] = '{`ATS_WMASK_CTLB, `ATS_WMASK_CTLA, `ATS_WMASK_CMP,
		`ATS_WMASK_CMP};

	// timer source: oscillator edges in async mode, every cycle otherwise
	wire osc_rise;
	ats_pin_sync u_osc_sync (
		.clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.pin(timer_osc_input_pin),
		.rise(osc_rise)
	);
	wire src_tick = async_q ? osc_rise : clk_en;

	// buffered registers: temporary copy for software, live copy for the timer
	ats_byte_t buf_tmp [4];
	ats_byte_t buf_live [4];
	wire [3:0] xfer;
	for (genvar i = 0; i < 4; i++) begin : g_buf
		ats_byte_t tmp_q;
		ats_byte_t live_q;
		logic busy_q;
		assign xfer[i] = busy_q & src_tick & ~wr_buf[i];
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				tmp_q <= `ATS_RST_BYTE;
				live_q <= `ATS_RST_BYTE;
				busy_q <= 1'b0;
			end else if (clk_en) begin
				if (wr_buf[i]) begin
					tmp_q <= wd & wmask[i];
				end
				if (wr_buf[i] & ~async_q) begin
					live_q <= wd & wmask[i];
				end else if (xfer[i]) begin
					live_q <= tmp_q;
				end
				busy_q <= (wr_buf[i] & async_q) | (busy_q & ~xfer[i]);
			end
		end
		assign buf_tmp[i] = tmp_q;
		assign buf_live[i] = live_q;
		assign busy[i] = busy_q;
	end

	// live views used by the counter
	wire ats_byte_t cmp_a = buf_live[`ATS_BUF_CMPA];
	wire ats_byte_t cmp_b = buf_live[`ATS_BUF_CMPB];
	wire ats_byte_t ctl_a = buf_live[`ATS_BUF_CTLA];
	wire ats_byte_t ctl_b = buf_live[`ATS_BUF_CTLB];
	wire [2:0] wgm = {ctl_b[3], ctl_a[1:0]};
	wire pc_mode = (wgm[1:0] == `ATS_WGM_PC);
	wire ctc_mode = (wgm == `ATS_WGM_CTC);
	wire ats_byte_t top = (wgm[2] | ctc_mode) ? cmp_a : `ATS_CNT_MAX;

	// prescaler with its reset bit
	wire cnt_tick;
	ats_prescaler u_presc (
		.clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.src_tick(src_tick),
		.clr(psr_q),
		.sel(ctl_b[2:0]),
		.tick(cnt_tick)
	);

	// counter write path, direct in sync mode, via temporary in async mode
	logic cnt_busy_q;
	wire cnt_xfer = cnt_busy_q & src_tick & ~wr_cnt;
	wire cnt_load = (wr_cnt & ~async_q) | cnt_xfer;
	// a pending transfer always loads the temporary, even if async was dropped meanwhile
	wire ats_byte_t cnt_load_val = wr_cnt ? wd : cnt_tmp_q;
	assign busy[`ATS_BUF_CNT] = cnt_busy_q;

	// next count for up and up/down sequences
	wire at_top = (cnt_q == top);
	wire at_bot = (cnt_q == `ATS_CNT_BOTTOM);
	wire go_down = pc_mode & (((dir_q == ATS_UP) & at_top) | ((dir_q == ATS_DOWN) & ~at_bot));
	wire ats_dir_t dir_d = go_down ? ATS_DOWN : ATS_UP;
	wire ats_byte_t cnt_next = go_down ? cnt_q - 8'h01 :
		(~pc_mode & at_top) ? `ATS_CNT_BOTTOM : cnt_q + 8'h01;
	wire ovf_evt = cnt_tick & (pc_mode ? ((dir_q == ATS_DOWN) & at_bot) :
		ctc_mode ? (cnt_q == `ATS_CNT_MAX) : at_top);

	// matches, blocked on the tick after a counter write
	wire match_a = cnt_tick & ~block_q & (cnt_q == cmp_a);
	wire match_b = cnt_tick & ~block_q & (cnt_q == cmp_b);
	wire [2:0] evt = {match_b, match_a, ovf_evt};

	// counter, direction and compare block
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= `ATS_RST_BYTE;
			cnt_tmp_q <= `ATS_RST_BYTE;
			cnt_busy_q <= 1'b0;
			dir_q <= ATS_UP;
			block_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_cnt) begin
				cnt_tmp_q <= wd;
			end
			cnt_busy_q <= (wr_cnt & async_q) | (cnt_busy_q & ~cnt_xfer);
			if (cnt_load) begin
				cnt_q <= cnt_load_val;
				block_q <= 1'b1;
			end else if (cnt_tick) begin
				cnt_q <= cnt_next;
				dir_q <= dir_d;
				block_q <= 1'b0;
			end
		end
	end

	// flags: events win over both kinds of clear
	wire [2:0] w1c = wr_flags ? wd[2:0] : `ATS_RST_FLAGS;
	wire [2:0] flags_d = evt | (flags_q & ~w1c & ~irq_vector_ack);
	// prescaler reset bit: cleared at once, after an async tick, never in sync mode
	wire psr_set = wr_gtc & wd[`ATS_BIT_PSR];
	wire psr_keep = tsm_q | (async_q & ~src_tick);
	wire psr_d = psr_set | (psr_q & psr_keep);
	// compare output actions on a match
	wire [1:0] com_a = ctl_a[7:6];
	wire [1:0] com_b = ctl_a[5:4];
	wire wave_a_d = ~match_a ? wave_a_q : (com_a == `ATS_COM_TOGGLE) ? ~wave_a_q :
		(com_a == `ATS_COM_CLEAR) ? 1'b0 : (com_a == `ATS_COM_SET) ? 1'b1 : wave_a_q;
	wire wave_b_d = ~match_b ? wave_b_q : (com_b == `ATS_COM_TOGGLE) ? ~wave_b_q :
		(com_b == `ATS_COM_CLEAR) ? 1'b0 : (com_b == `ATS_COM_SET) ? 1'b1 : wave_b_q;

	// control, status and output flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= `ATS_RST_FLAGS;
			mask_q <= `ATS_RST_FLAGS;
			tsm_q <= 1'b0;
			psr_q <= 1'b0;
			ext_q <= 1'b0;
			async_q <= 1'b0;
			irq_q <= `ATS_RST_FLAGS;
			wave_a_q <= 1'b0;
			wave_b_q <= 1'b0;
			osc_run_q <= 1'b0;
			ext_buf_q <= 1'b0;
		end else if (clk_en) begin
			flags_q <= flags_d;
			psr_q <= psr_d;
			if (wr_mask) begin
				mask_q <= wd[2:0];
			end
			if (wr_gtc) begin
				tsm_q <= wd[`ATS_BIT_TSM];
			end
			if (wr_async_status) begin
				ext_q <= wd[`ATS_BIT_EXT];
				async_q <= wd[`ATS_BIT_ASYNC];
			end
			irq_q <= flags_q & mask_q & {3{global_irq_enable}};
			wave_a_q <= wave_a_d;
			wave_b_q <= wave_b_d;
			osc_run_q <= ~ext_q;
			ext_buf_q <= ext_q & async_q;
		end
	end

	// read data; reserved bits read zero
	wire ats_byte_t rd_byte =
		(idx == `ATS_IDX_FLAGS) ? {5'h00, flags_q} :
		(idx == `ATS_IDX_GTC) ? {tsm_q, 5'h00, psr_q, 1'b0} :
		(idx == `ATS_IDX_MASK) ? {5'h00, mask_q} :
		(idx == `ATS_IDX_ASYNC_STATUS) ? {1'b0, ext_q, async_q, busy} :
		(idx == `ATS_IDX_CNT) ? cnt_q :
		(idx == `ATS_IDX_CMPA) ? buf_tmp[`ATS_BUF_CMPA] :
		(idx == `ATS_IDX_CMPB) ? buf_tmp[`ATS_BUF_CMPB] :
		(idx == `ATS_IDX_CTLA) ? buf_tmp[`ATS_BUF_CTLA] :
		(idx == `ATS_IDX_CTLB) ? buf_tmp[`ATS_BUF_CTLB] : `ATS_RST_BYTE;

	// wishbone answer one cycle after the request, unmapped reads give zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else if (clk_en) begin
			ack_q <= req;
			if (rd) begin
				dat_q <= {24'h00_0000, rd_byte};
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign irq_request = irq_q;
	assign wave_out_a = wave_a_q;
	assign wave_out_b = wave_b_q;
	assign osc_run = osc_run_q;
	assign ext_clk_buf_en = ext_buf_q;
	assign prescaler_reset = psr_q;

	// checks on the register and flag behaviour
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_busy_set: assert property (clk_en & wr_buf[`ATS_BUF_CMPA] & async_q
		|=> busy[`ATS_BUF_CMPA])
		else $error("compare a busy not set by async write");
	a_busy_clear: assert property (clk_en & cnt_busy_q & src_tick & ~wr_cnt
		|=> ~cnt_busy_q && cnt_q == $past(cnt_tmp_q))
		else $error("counter transfer or busy clear wrong");
	a_read_live: assert property (clk_en & rd & (idx == `ATS_IDX_CNT)
		|=> wb_ack_o && wb_dat_o[7:0] == $past(cnt_q))
		else $error("counter read not live");
	a_read_temp: assert property (clk_en & rd & (idx == `ATS_IDX_CMPB)
		|=> wb_dat_o[7:0] == $past(buf_tmp[`ATS_BUF_CMPB]))
		else $error("compare b read not from temporary");
	a_irq_gate: assert property (clk_en & ~global_irq_enable |=> irq_request == 3'h0)
		else $error("request without global enable");
	a_flag_w1c: assert property (clk_en & wr_flags & wd[0] & ~ovf_evt
		|=> ~flags_q[0])
		else $error("overflow flag not cleared by write one");
	a_flag_set: assert property (clk_en & match_a & irq_vector_ack[1]
		|=> flags_q[1])
		else $error("compare a match lost against clear");
	a_psr_hold: assert property (clk_en & tsm_q & psr_q & ~wr_gtc |=> psr_q)
		else $error("prescaler reset dropped in sync mode");
	a_psr_clear: assert property (clk_en & psr_q & ~tsm_q & ~async_q & ~psr_set
		|=> ~psr_q)
		else $error("prescaler reset bit not cleared");
	a_match_block: assert property (clk_en & cnt_load |=> ~(match_a | match_b))
		else $error("match right after counter write");

	// vector clear, overflow set, request, async hold, control b write mask and clock buffer
	a_flag_vector: assert property (clk_en & irq_vector_ack[2] & ~match_b
		|=> ~flags_q[2])
		else $error("compare b flag not cleared by vector");
	a_ovf_set: assert property (clk_en & ovf_evt |=> flags_q[0])
		else $error("overflow event did not set flag");
	a_irq_set: assert property (clk_en & flags_q[2] & mask_q[2] & global_irq_enable
		|=> irq_request[2])
		else $error("enabled compare b flag gave no request");
	a_psr_async: assert property (clk_en & psr_q & async_q & ~src_tick
		|=> psr_q)
		else $error("async prescaler reset dropped before tick");
	a_ctlb_mask: assert property (clk_en & wr_buf[`ATS_BUF_CTLB]
		|=> buf_tmp[`ATS_BUF_CTLB] == ($past(wd) & `ATS_WMASK_CTLB))
		else $error("control b reserved bits written");
	a_ext_buf: assert property (clk_en & ext_q & async_q |=> ext_clk_buf_en)
		else $error("external clock buffer not enabled");

	c_async_write: cover property (wr_buf[`ATS_BUF_CMPA] & async_q ##[1:50] xfer[`ATS_BUF_CMPA]);
	c_match_a: cover property (match_a);
	c_ovf: cover property (ovf_evt & pc_mode);
	c_psr_async: cover property (psr_q & async_q ##1 ~psr_q);
endmodule
`default_nettype wire

// [sim/ats_core_model.sv]
// processor-side partner: timer oscillator source and interrupt vector execution
`timescale 1ns/100ps
`default_nettype none
module ats_core_model (
	input wire logic ref_clk, // system clock
	input wire logic osc_on, // oscillator runs while high
	input wire logic auto_ack, // vectors are executed while high
	input wire logic [2:0] irq_request, // requests from the timer
	output logic [2:0] irq_vector_ack, // one-cycle vector executed pulse
	output logic osc_pin // oscillator pin level
);
	logic [2:0] div_q;
	logic [2:0] hold_q;
	initial begin
		irq_vector_ack = 3'h0;
		osc_pin = 1'b0;
		div_q = 3'h0;
		hold_q = 3'h0;
	end
	// slow oscillator: a pin edge every five clocks, frozen outside runs
	always @(posedge ref_clk) begin
		if (osc_on) begin
			div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
			if (div_q == 3'h4) osc_pin <= ~osc_pin;
		end
	end
	// vector execution: one pulse, then a pause while the flag settles
	always @(posedge ref_clk) begin
		irq_vector_ack <= 3'h0;
		if (hold_q != 3'h0) begin
			hold_q <= hold_q - 3'h1;
		end else if (auto_ack && irq_request != 3'h0) begin
			hold_q <= 3'h5;
			if (irq_request[2]) irq_vector_ack <= 3'h4;
			else if (irq_request[1]) irq_vector_ack <= 3'h2;
			else irq_vector_ack <= 3'h1;
		end
	end
endmodule
`default_nettype wire

// [sim/ats_timer_tb.sv]
// self-checking bench for the timer register block
`timescale 1ns/100ps
`default_nettype none
`include "ats_cfg.svh"
module ats_timer_tb import ats_pkg::*;;
	typedef struct {
		logic [7:0] idx;
		ats_byte_t wdat;
		ats_byte_t exp;
	} ats_row_t;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [9:0] wb_adr_i = 10'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic osc_pin;
	logic global_irq_enable = 1'b0;
	logic osc_on = 1'b0;
	logic auto_ack = 1'b0;
	logic clk_en = 1'b1;
	logic [2:0] irq_vector_ack;
	logic [2:0] irq_request;
	logic wave_out_a;
	logic wave_out_b;
	logic osc_run;
	logic ext_clk_buf_en;
	logic prescaler_reset;
	int bad_count = 0;
	int num_checks = 0;
	ats_byte_t rd;
	int n;
	// write then read back: mask, compares, controls, status, unmapped
	ats_row_t rows [7] = '{
		'{`ATS_IDX_MASK, 8'hff, 8'h07}, '{`ATS_IDX_CMPA, 8'ha5, 8'ha5},
		'{`ATS_IDX_CMPB, 8'h5a, 8'h5a}, '{`ATS_IDX_CTLA, 8'hff, 8'hf3},
		'{`ATS_IDX_CTLB, 8'hf8, 8'h08}, '{`ATS_IDX_ASYNC_STATUS, 8'h9f, 8'h00},
		'{8'h10, 8'hff, 8'h00}};
	logic [7:0] rst_idx [8] = '{`ATS_IDX_FLAGS, `ATS_IDX_GTC, `ATS_IDX_MASK, `ATS_IDX_ASYNC_STATUS,
		`ATS_IDX_CTLA, `ATS_IDX_CTLB, `ATS_IDX_CMPA, `ATS_IDX_CMPB};

	always #5 ref_clk = ~ref_clk;

	ats_timer u_ats_timer (
		.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_osc_input_pin(osc_pin),
		.global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
		.irq_request(irq_request), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
		.osc_run(osc_run), .ext_clk_buf_en(ext_clk_buf_en), .prescaler_reset(prescaler_reset)
	);

	ats_core_model u_ats_core_model (
		.ref_clk(ref_clk), .osc_on(osc_on), .auto_ack(auto_ack),
		.irq_request(irq_request), .irq_vector_ack(irq_vector_ack), .osc_pin(osc_pin)
	);

	// verdict and end of run
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input ats_byte_t exp, input ats_byte_t got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one classic wishbone cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] idx, input ats_byte_t wd,
		output ats_byte_t q);
		int k;
		k = 0;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h00_0000, wd};
		do begin
			@(posedge ref_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			bad_count++;
			$display("Error wb_ack_o expected 1 seen %b", wb_ack_o);
			end_of_test();
		end
	endtask

	task automatic wr(input logic [7:0] idx, input ats_byte_t wd);
		ats_byte_t q;
		wb(1'b1, idx, wd, q);
	endtask

	task automatic rchk(input string nm, input logic [7:0] idx, input ats_byte_t exp);
		ats_byte_t q;
		wb(1'b0, idx, 8'h00, q);
		chk(nm, exp, q);
	endtask

	// reads until the value matches or the bound runs out
	task automatic poll(input string nm, input logic [7:0] idx, input ats_byte_t exp);
		ats_byte_t q;
		int k;
		for (k = 0; k < 40; k++) begin
			wb(1'b0, idx, 8'h00, q);
			if (q === exp) break;
		end
		chk(nm, exp, q);
	endtask

	initial begin
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		foreach (rst_idx[i]) rchk("reset value", rst_idx[i], 8'h00);
		chk("osc_run", 8'h01, {7'h00, osc_run});
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wdat);
			rchk("readback", rows[i].idx, rows[i].exp);
		end
		// both compare matches in synchronous mode
		wr(`ATS_IDX_MASK, 8'h00);
		// output a toggles, output b is set on its match
		wr(`ATS_IDX_CTLA, 8'h70);
		wr(`ATS_IDX_CMPA, 8'h05);
		wr(`ATS_IDX_CMPB, 8'h08);
		wr(`ATS_IDX_CNT, 8'h00);
		wr(`ATS_IDX_FLAGS, 8'h07);
		wr(`ATS_IDX_CTLB, 8'h01);
		poll("compare flags", `ATS_IDX_FLAGS, 8'h06);
		wr(`ATS_IDX_CTLB, 8'h00);
		chk("wave_out_a", 8'h01, {7'h00, wave_out_a});
		chk("wave_out_b", 8'h01, {7'h00, wave_out_b});
		wr(`ATS_IDX_FLAGS, 8'h02);
		rchk("w1c flags", `ATS_IDX_FLAGS, 8'h04);
		// request gated by the global bit, then executed by the core
		wr(`ATS_IDX_MASK, 8'h04);
		repeat (3) @(posedge ref_clk);
		chk("masked request", 8'h00, {5'h00, irq_request});
		global_irq_enable <= 1'b1;
		auto_ack <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (irq_request !== 3'h4 && n < 20);
		chk("request", 8'h04, {5'h00, irq_request});
		repeat (6) @(posedge ref_clk);
		rchk("vector clear", `ATS_IDX_FLAGS, 8'h00);
		chk("request after clear", 8'h00, {5'h00, irq_request});
		global_irq_enable <= 1'b0;
		auto_ack <= 1'b0;
		// overflow past the top value
		wr(`ATS_IDX_CNT, 8'hfd);
		wr(`ATS_IDX_CTLB, 8'h01);
		wr(`ATS_IDX_CTLB, 8'h00);
		rchk("overflow flag", `ATS_IDX_FLAGS, 8'h01);
		wr(`ATS_IDX_FLAGS, 8'h01);
		// clock enable low freezes the running counter: three ticks counted in all
		wr(`ATS_IDX_CNT, 8'h10);
		wr(`ATS_IDX_CTLB, 8'h01);
		clk_en <= 1'b0;
		repeat (20) @(posedge ref_clk);
		clk_en <= 1'b1;
		wr(`ATS_IDX_CTLB, 8'h00);
		rchk("frozen count", `ATS_IDX_CNT, 8'h13);
		// phase correct with top at compare a: overflow at the bottom turn
		wr(`ATS_IDX_CTLA, 8'h01);
		wr(`ATS_IDX_CNT, 8'h02);
		wr(`ATS_IDX_CTLB, 8'h09);
		poll("bottom turn flags", `ATS_IDX_FLAGS, 8'h03);
		wr(`ATS_IDX_CTLB, 8'h00);
		wr(`ATS_IDX_FLAGS, 8'h03);
		// prescaler reset: self clearing, held in sync mode
		wr(`ATS_IDX_GTC, 8'h02);
		rchk("prescaler reset", `ATS_IDX_GTC, 8'h00);
		wr(`ATS_IDX_GTC, 8'h82);
		rchk("held reset", `ATS_IDX_GTC, 8'h82);
		chk("prescaler_reset", 8'h01, {7'h00, prescaler_reset});
		wr(`ATS_IDX_GTC, 8'h00);
		rchk("released reset", `ATS_IDX_GTC, 8'h00);
		// asynchronous mode: external clock first, then select
		wr(`ATS_IDX_ASYNC_STATUS, 8'h40);
		repeat (3) @(posedge ref_clk);
		chk("osc_run", 8'h00, {7'h00, osc_run});
		chk("ext_clk_buf_en", 8'h00, {7'h00, ext_clk_buf_en});
		wr(`ATS_IDX_ASYNC_STATUS, 8'h60);
		repeat (3) @(posedge ref_clk);
		chk("ext_clk_buf_en", 8'h01, {7'h00, ext_clk_buf_en});
		wr(`ATS_IDX_CNT, 8'h00);
		wr(`ATS_IDX_CMPB, 8'h08);
		wr(`ATS_IDX_CTLA, 8'h00);
		wr(`ATS_IDX_CTLB, 8'h00);
		wr(`ATS_IDX_CMPA, 8'h33);
		rchk("busy set", `ATS_IDX_ASYNC_STATUS, 8'h7f);
		rchk("temporary read", `ATS_IDX_CMPA, 8'h33);
		wr(`ATS_IDX_GTC, 8'h02);
		rchk("async reset held", `ATS_IDX_GTC, 8'h02);
		osc_on <= 1'b1;
		poll("busy clear", `ATS_IDX_ASYNC_STATUS, 8'h60);
		poll("async reset done", `ATS_IDX_GTC, 8'h00);
		osc_on <= 1'b0;
		wr(`ATS_IDX_ASYNC_STATUS, 8'h00);
		repeat (3) @(posedge ref_clk);
		chk("osc_run", 8'h01, {7'h00, osc_run});
		end_of_test();
	end
endmodule
`default_nettype wire
